// ===== design/fmpc_top.sv
// float-mode pulse configuration register bank with sample sign decode
`timescale 1ns/1ps
`default_nettype none
`include "fmpc_defs.svh"

module fmpc_top (
    // clock, reset, enable
    input  wire logic                 sys_clk,
    input  wire logic                 rst,
    input  wire logic                 clk_en,
    // register access from host serial port
    input  wire fmpc_pkg::fmpc_req_t  reg_req,
    output logic                      rd_valid_r,
    output logic                      rd_hit_r,
    output logic [15:0]               rd_data_r,
    // sample sign request and answer
    input  wire fmpc_pkg::fmpc_sample_t sample_req,
    output logic                      sign_valid_r,
    output logic                      sign_sub_r,
    // slot B float pulse configuration
    output logic [2:0]                led_onehot_r,
    output logic [4:0]                pulse_width_r,
    output logic [11:0]               pulse_width_cyc_r,
    output logic [7:0]                first_delay_r,
    output logic                      float_on_r,
    output logic [4:0]                precon_time_r,
    // analog front end control
    output logic                      integrator_buffer_enable_r
);

    // -----------------------------------------------------------------
    // decoding helpers
    // -----------------------------------------------------------------

    // one-hot LED driver from the two-bit choice, zero for no LED
    function automatic logic [2:0] led_decode(input logic [1:0] sel);
        logic [2:0] v;
        v = 3'h0;
        if (sel != 2'h0)
        begin
            v[sel - 2'h1] = 1'b1;
        end
        return v;
    endfunction

    // subtract flag for a sample position from a pair of sign codes
    function automatic logic sign_of(input logic [1:0] m12, input logic [1:0] m34,
                                     input logic [1:0] pos);
        logic s;
        s = 1'b0;
        unique case (pos)
            `FMPC_POS_FIRST:  s = m12[1];
            `FMPC_POS_SECOND: s = m12[0];
            `FMPC_POS_THIRD:  s = m34[1];
            default:          s = m34[0];
        endcase
        return s;
    endfunction

    // readback image of a register, reserved bits as zero
    function automatic logic [15:0] read_image(input fmpc_pkg::fmpc_state_t s,
                                               input logic [7:0] a);
        logic [15:0] v;
        v = 16'h0000;
        unique case (a)
            `FMPC_ADDR_LED_TIMING_B:
            begin
                v[`FMPC_LED_SEL_F] = s.led_sel;
                v[`FMPC_WIDTH_F]   = s.width;
                v[`FMPC_OFFSET_F]  = s.offset;
            end
            `FMPC_ADDR_SAMPLE_MATH:
            begin
                v[`FMPC_MATH34_B_F] = s.math34_b;
                v[`FMPC_MATH34_A_F] = s.math34_a;
                v[`FMPC_INTBUF_BIT] = s.intbuf;
                v[`FMPC_MATH12_B_F] = s.math12_b;
                v[`FMPC_MATH12_A_F] = s.math12_a;
            end
            `FMPC_ADDR_ENABLE_B:
            begin
                v[`FMPC_FLT_EN_F] = s.flt_en;
                v[`FMPC_PRECON_F] = s.precon;
            end
            default: v = 16'h0000;
        endcase
        return v;
    endfunction

    // -----------------------------------------------------------------
    // state
    // -----------------------------------------------------------------

    fmpc_pkg::fmpc_state_t st_r;
    fmpc_pkg::fmpc_state_t st_nxt;
    logic                  hit;

    // address decode for mapped registers
    assign hit = (reg_req.addr == `FMPC_ADDR_LED_TIMING_B) ||
                 (reg_req.addr == `FMPC_ADDR_SAMPLE_MATH) ||
                 (reg_req.addr == `FMPC_ADDR_ENABLE_B);

    // next state: register writes, readback, derived outputs, sign decode
    always_comb
    begin
        st_nxt = st_r;
        // field writes keep only documented fields
        if (reg_req.wr && reg_req.addr == `FMPC_ADDR_LED_TIMING_B)
        begin
            st_nxt.led_sel = reg_req.wdata[`FMPC_LED_SEL_F];
            st_nxt.width   = reg_req.wdata[`FMPC_WIDTH_F];
            st_nxt.offset  = reg_req.wdata[`FMPC_OFFSET_F];
        end
        if (reg_req.wr && reg_req.addr == `FMPC_ADDR_SAMPLE_MATH)
        begin
            st_nxt.math34_b = reg_req.wdata[`FMPC_MATH34_B_F];
            st_nxt.math34_a = reg_req.wdata[`FMPC_MATH34_A_F];
            st_nxt.intbuf   = reg_req.wdata[`FMPC_INTBUF_BIT];
            st_nxt.math12_b = reg_req.wdata[`FMPC_MATH12_B_F];
            st_nxt.math12_a = reg_req.wdata[`FMPC_MATH12_A_F];
        end
        if (reg_req.wr && reg_req.addr == `FMPC_ADDR_ENABLE_B)
        begin
            st_nxt.flt_en = reg_req.wdata[`FMPC_FLT_EN_F];
            st_nxt.precon = reg_req.wdata[`FMPC_PRECON_F];
        end
        // derived configuration, reserved bits never consulted
        st_nxt.led_onehot = led_decode(st_nxt.led_sel);
        st_nxt.width_cyc  = 12'(st_nxt.width * `FMPC_STEP_CYC);
        st_nxt.float_on   = (st_nxt.flt_en == `FMPC_FLT_EN_ON);
        // readback answers one cycle after the request
        st_nxt.rd_valid = reg_req.rd;
        st_nxt.rd_hit   = reg_req.rd && hit;
        st_nxt.rd_data  = reg_req.rd ? read_image(st_r, reg_req.addr) : 16'h0000;
        // sample sign from position within the group of four
        st_nxt.sign_valid = sample_req.valid;
        st_nxt.sign_sub   = 1'b0;
        if (sample_req.valid)
        begin
            st_nxt.sign_sub = sample_req.slot_b ?
                sign_of(st_r.math12_b, st_r.math34_b, sample_req.pulse_num[1:0]) :
                sign_of(st_r.math12_a, st_r.math34_a, sample_req.pulse_num[1:0]);
        end
    end

    // state register, reset overrides the clock enable
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            st_r            <= '0;
            st_r.led_sel    <= `FMPC_RST_LED_SEL;
            st_r.width      <= `FMPC_RST_WIDTH;
            st_r.offset     <= `FMPC_RST_OFFSET;
            st_r.math34_b   <= `FMPC_RST_MATH;
            st_r.math34_a   <= `FMPC_RST_MATH;
            st_r.math12_b   <= `FMPC_RST_MATH;
            st_r.math12_a   <= `FMPC_RST_MATH;
            st_r.flt_en     <= `FMPC_RST_FLT_EN;
            st_r.precon     <= `FMPC_RST_PRECON;
            st_r.width_cyc  <= 12'(`FMPC_RST_WIDTH * `FMPC_STEP_CYC);
        end
        else if (clk_en)
        begin
            st_r <= st_nxt;
        end
    end

    // -----------------------------------------------------------------
    // outputs
    // -----------------------------------------------------------------

    // all outputs straight from state flops
    assign rd_valid_r                 = st_r.rd_valid;
    assign rd_hit_r                   = st_r.rd_hit;
    assign rd_data_r                  = st_r.rd_data;
    assign sign_valid_r               = st_r.sign_valid;
    assign sign_sub_r                 = st_r.sign_sub;
    assign led_onehot_r               = st_r.led_onehot;
    assign pulse_width_r              = st_r.width;
    assign pulse_width_cyc_r          = st_r.width_cyc;
    assign first_delay_r              = st_r.offset;
    assign float_on_r                 = st_r.float_on;
    assign precon_time_r              = st_r.precon;
    assign integrator_buffer_enable_r = st_r.intbuf;

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------

    // led choice lands as one-hot driver select
    a_led_choice_decode: assert property (@(posedge sys_clk) disable iff (rst)
        (clk_en && reg_req.wr && reg_req.addr == `FMPC_ADDR_LED_TIMING_B) |=>
        (led_onehot_r[0] == ($past(reg_req.wdata[`FMPC_LED_SEL_F]) == 2'h1)) &&
        (led_onehot_r[1] == ($past(reg_req.wdata[`FMPC_LED_SEL_F]) == 2'h2)) &&
        (led_onehot_r[2] == ($past(reg_req.wdata[`FMPC_LED_SEL_F]) == 2'h3)))
        else $error("led driver select wrong");

    // pulse width in microsecond steps
    a_width_cycles: assert property (@(posedge sys_clk) disable iff (rst)
        (clk_en && reg_req.wr && reg_req.addr == `FMPC_ADDR_LED_TIMING_B) |=>
        (pulse_width_cyc_r == 12'($past(reg_req.wdata[`FMPC_WIDTH_F]) * `FMPC_STEP_CYC)))
        else $error("pulse width cycles wrong");

    // first pulse delay stored
    a_first_delay: assert property (@(posedge sys_clk) disable iff (rst)
        (clk_en && reg_req.wr && reg_req.addr == `FMPC_ADDR_LED_TIMING_B) |=>
        (first_delay_r == $past(reg_req.wdata[`FMPC_OFFSET_F])))
        else $error("first pulse delay wrong");

    // third and fourth sample signs
    a_sign_pair_two: assert property (@(posedge sys_clk) disable iff (rst)
        (clk_en && sample_req.valid && sample_req.pulse_num[1]) |=>
        sign_valid_r && (sign_sub_r == ($past(sample_req.slot_b) ?
            $past(st_r.math34_b[~sample_req.pulse_num[0]]) :
            $past(st_r.math34_a[~sample_req.pulse_num[0]]))))
        else $error("third or fourth sample sign wrong");

    // first and second sample signs
    a_sign_pair_one: assert property (@(posedge sys_clk) disable iff (rst)
        (clk_en && sample_req.valid && !sample_req.pulse_num[1]) |=>
        sign_valid_r && (sign_sub_r == ($past(sample_req.slot_b) ?
            $past(st_r.math12_b[~sample_req.pulse_num[0]]) :
            $past(st_r.math12_a[~sample_req.pulse_num[0]]))))
        else $error("first or second sample sign wrong");

    // same sign four pulses later when settings hold
    a_sign_repeat: assert property (@(posedge sys_clk) disable iff (rst)
        (clk_en && sample_req.valid && !reg_req.wr) ##1
        (clk_en && sample_req.valid && !reg_req.wr &&
         sample_req.slot_b == $past(sample_req.slot_b) &&
         sample_req.pulse_num == $past(sample_req.pulse_num) + `FMPC_POS_GROUP) |=>
        (sign_sub_r == $past(sign_sub_r)))
        else $error("sign pattern not repeated");

    // integrator buffer enable follows its bit
    a_intbuf_bit: assert property (@(posedge sys_clk) disable iff (rst)
        (clk_en && reg_req.wr && reg_req.addr == `FMPC_ADDR_SAMPLE_MATH) |=>
        (integrator_buffer_enable_r == $past(reg_req.wdata[`FMPC_INTBUF_BIT])))
        else $error("integrator buffer enable wrong");

    // float on only for code 3
    a_float_enable: assert property (@(posedge sys_clk) disable iff (rst)
        (clk_en && reg_req.wr && reg_req.addr == `FMPC_ADDR_ENABLE_B) |=>
        (float_on_r == ($past(reg_req.wdata[`FMPC_FLT_EN_F]) == `FMPC_FLT_EN_ON)))
        else $error("float enable decode wrong");

    // preconditioning time stored
    a_precon_time: assert property (@(posedge sys_clk) disable iff (rst)
        (clk_en && reg_req.wr && reg_req.addr == `FMPC_ADDR_ENABLE_B) |=>
        (precon_time_r == $past(reg_req.wdata[`FMPC_PRECON_F])))
        else $error("preconditioning time wrong");

    // reserved bits dropped on readback
    a_reserved_zero: assert property (@(posedge sys_clk) disable iff (rst)
        (clk_en && reg_req.wr && reg_req.addr == `FMPC_ADDR_SAMPLE_MATH) ##1
        (clk_en && reg_req.rd && !reg_req.wr && reg_req.addr == `FMPC_ADDR_SAMPLE_MATH) |=>
        (rd_data_r == ($past(reg_req.wdata, 2) & 16'h0FE6)))
        else $error("reserved bits not ignored");

    // defaults after reset
    a_reset_defaults: assert property (@(posedge sys_clk)
        rst |=> (pulse_width_r == `FMPC_RST_WIDTH) && (first_delay_r == `FMPC_RST_OFFSET) &&
        (precon_time_r == `FMPC_RST_PRECON) && !float_on_r && !integrator_buffer_enable_r)
        else $error("reset defaults wrong");

    // frozen while the enable is low
    a_enable_freeze: assert property (@(posedge sys_clk) disable iff (rst)
        !clk_en |=> $stable(sign_sub_r) && $stable(rd_valid_r) && $stable(led_onehot_r))
        else $error("state moved while disabled");

    // unmapped reads answer with no hit and zero data
    a_unmapped_read: assert property (@(posedge sys_clk) disable iff (rst)
        (clk_en && reg_req.rd && !hit) |=>
        rd_valid_r && !rd_hit_r && (rd_data_r == 16'h0000))
        else $error("unmapped read answered wrongly");

    // read answer only after a read strobe
    a_read_pulse: assert property (@(posedge sys_clk) disable iff (rst)
        (clk_en && !reg_req.rd) |=>
        !rd_valid_r && !rd_hit_r && (rd_data_r == 16'h0000))
        else $error("read answer without request");

    // no sign answer without a sample request
    a_sign_idle: assert property (@(posedge sys_clk) disable iff (rst)
        (clk_en && !sample_req.valid) |=>
        !sign_valid_r && !sign_sub_r)
        else $error("sign answer without request");

    // configuration outputs hold while the enable is low
    a_config_freeze: assert property (@(posedge sys_clk) disable iff (rst)
        !clk_en |=> $stable(float_on_r) && $stable(pulse_width_r) &&
        $stable(first_delay_r) && $stable(precon_time_r))
        else $error("configuration moved while disabled");

endmodule // fmpc_top
`default_nettype wire

// ===== common/fmpc_defs.svh
// register offsets, field positions, reset values and timing counts
`ifndef FMPC_DEFS_SVH
`define FMPC_DEFS_SVH
// ---------------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------------
`define FMPC_ADDR_LED_TIMING_B 8'h3F
`define FMPC_ADDR_SAMPLE_MATH  8'h58
`define FMPC_ADDR_ENABLE_B     8'h59
// ---------------------------------------------------------------------
// field positions
// ---------------------------------------------------------------------
`define FMPC_LED_SEL_F   15:14
`define FMPC_WIDTH_F     12:8
`define FMPC_OFFSET_F    7:0
`define FMPC_MATH34_B_F  11:10
`define FMPC_MATH34_A_F  9:8
`define FMPC_INTBUF_BIT  7
`define FMPC_MATH12_B_F  6:5
`define FMPC_MATH12_A_F  2:1
`define FMPC_FLT_EN_F    14:13
`define FMPC_PRECON_F    12:8
// ---------------------------------------------------------------------
// reset values and codes
// ---------------------------------------------------------------------
`define FMPC_RST_LED_SEL 2'h0
`define FMPC_RST_WIDTH   5'h03
`define FMPC_RST_OFFSET  8'h20
`define FMPC_RST_MATH    2'h0
`define FMPC_RST_FLT_EN  2'h0
`define FMPC_RST_PRECON  5'h08
`define FMPC_FLT_EN_ON   2'h3
`define FMPC_POS_FIRST   2'h0
`define FMPC_POS_SECOND  2'h1
`define FMPC_POS_THIRD   2'h2
`define FMPC_POS_GROUP   8'h04
// ---------------------------------------------------------------------
// timing: pulse width step in ns, clock period in ns
// ---------------------------------------------------------------------
`define FMPC_STEP_NS     1000
`define FMPC_CLK_NS      8
`define FMPC_STEP_CYC    ((`FMPC_STEP_NS + `FMPC_CLK_NS - 1) / `FMPC_CLK_NS)
`endif

// ===== common/fmpc_pkg.sv
// types shared by the float-mode pulse configuration bank
package fmpc_pkg;
    // register access request from the host serial port logic
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } fmpc_req_t;

    // request for the sign of one float-mode sample
    typedef struct packed {
        logic       valid;
        logic       slot_b;
        logic [7:0] pulse_num;
    } fmpc_sample_t;

    // whole module state
    typedef struct packed {
        logic [1:0]  led_sel;
        logic [4:0]  width;
        logic [7:0]  offset;
        logic [1:0]  math34_b;
        logic [1:0]  math34_a;
        logic        intbuf;
        logic [1:0]  math12_b;
        logic [1:0]  math12_a;
        logic [1:0]  flt_en;
        logic [4:0]  precon;
        logic [2:0]  led_onehot;
        logic [11:0] width_cyc;
        logic        float_on;
        logic        rd_valid;
        logic        rd_hit;
        logic [15:0] rd_data;
        logic        sign_valid;
        logic        sign_sub;
    } fmpc_state_t;
endpackage

// ===== sim/fmpc_top_test.sv
// self-checking testbench for the float-mode pulse configuration bank
`timescale 1ns/1ps
`default_nettype none
`include "fmpc_defs.svh"

module fmpc_top_test;
    // ---------------------------------------------------------------------
    // clock, reset and stimulus signals
    // ---------------------------------------------------------------------
    logic                   sys_clk = 1'b0;
    logic                   rst     = 1'b1;
    logic                   clk_en  = 1'b1;
    fmpc_pkg::fmpc_req_t    req     = '0;
    fmpc_pkg::fmpc_sample_t sreq    = '0;
    logic                   rd_valid_r;
    logic                   rd_hit_r;
    logic [15:0]            rd_data_r;
    logic                   sign_valid_r;
    logic                   sign_sub_r;
    logic [2:0]             led_onehot_r;
    logic [4:0]             pulse_width_r;
    logic [11:0]            pulse_width_cyc_r;
    logic [7:0]             first_delay_r;
    logic                   float_on_r;
    logic [4:0]             precon_time_r;
    logic                   integrator_buffer_enable_r;
    int                     n_mismatch      = 0;
    int                     samples_checked = 0;
    int                     cycles          = 0;

    // 125 MHz clock
    always #4 sys_clk = ~sys_clk;

    fmpc_top i_dut (
        .sys_clk                    (sys_clk),
        .rst                        (rst),
        .clk_en                     (clk_en),
        .reg_req                    (req),
        .rd_valid_r                 (rd_valid_r),
        .rd_hit_r                   (rd_hit_r),
        .rd_data_r                  (rd_data_r),
        .sample_req                 (sreq),
        .sign_valid_r               (sign_valid_r),
        .sign_sub_r                 (sign_sub_r),
        .led_onehot_r               (led_onehot_r),
        .pulse_width_r              (pulse_width_r),
        .pulse_width_cyc_r          (pulse_width_cyc_r),
        .first_delay_r              (first_delay_r),
        .float_on_r                 (float_on_r),
        .precon_time_r              (precon_time_r),
        .integrator_buffer_enable_r (integrator_buffer_enable_r)
    );

    // ---------------------------------------------------------------------
    // shared tasks
    // ---------------------------------------------------------------------
    task automatic complete_run();
        if (n_mismatch == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one bus cycle; read answer is settled when this returns
    task automatic reg_io(input logic wr, input logic rd, input logic [7:0] a,
                          input logic [15:0] d);
        @(negedge sys_clk);
        req.wr    = wr;
        req.rd    = rd;
        req.addr  = a;
        req.wdata = d;
        @(negedge sys_clk);
        req.wr = 1'b0;
        req.rd = 1'b0;
    endtask

    task automatic read_check(input logic [7:0] a, input logic [15:0] exp, input logic hit);
        reg_io(1'b0, 1'b1, a, 16'h0000);
        check("rd_valid", 16'(rd_valid_r), 16'h0001);
        check("rd_hit", 16'(rd_hit_r), 16'(hit));
        check("rd_data", rd_data_r, exp);
        @(negedge sys_clk);
        check("rd_valid low", 16'(rd_valid_r), 16'h0000);
    endtask

    // ---------------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------------
    // field defaults after reset
    task automatic test_reset();
        check("width", 16'(pulse_width_r), 16'h0003);
        check("width cyc", 16'(pulse_width_cyc_r), 16'h0177);
        check("delay", 16'(first_delay_r), 16'h0020);
        check("precon", 16'(precon_time_r), 16'h0008);
        check("float on", 16'(float_on_r), 16'h0000);
        check("led", 16'(led_onehot_r), 16'h0000);
        check("intbuf", 16'(integrator_buffer_enable_r), 16'h0000);
        read_check(`FMPC_ADDR_LED_TIMING_B, 16'h0320, 1'b1);
        read_check(`FMPC_ADDR_SAMPLE_MATH, 16'h0000, 1'b1);
        read_check(`FMPC_ADDR_ENABLE_B, 16'h0800, 1'b1);
    endtask

    // every led code, with width and delay at varied values
    task automatic test_led_select();
        logic [4:0] w;
        logic [7:0] dly;
        for (int s = 0; s < 4; s++)
        begin
            w   = 5'(s * 10 + 1);
            dly = 8'(8'hFF - s);
            reg_io(1'b1, 1'b0, `FMPC_ADDR_LED_TIMING_B, {2'(s), 1'b0, w, dly});
            check("led", 16'(led_onehot_r), (s == 0) ? 16'h0000 : 16'(1 << (s - 1)));
            check("width", 16'(pulse_width_r), 16'(w));
            check("width cyc", 16'(pulse_width_cyc_r), 16'(w * 125));
            check("delay", 16'(first_delay_r), 16'(dly));
        end
    endtask

    // reserved bits dropped, integrator buffer bit honoured
    task automatic test_reserved();
        // write, then read back in the very next cycle
        @(negedge sys_clk);
        req.wr    = 1'b1;
        req.addr  = `FMPC_ADDR_SAMPLE_MATH;
        req.wdata = 16'hFFFF;
        @(negedge sys_clk);
        req.wr = 1'b0;
        req.rd = 1'b1;
        @(negedge sys_clk);
        req.rd = 1'b0;
        check("rd back", rd_data_r, 16'h0FE6);
        check("intbuf", 16'(integrator_buffer_enable_r), 16'h0001);
        read_check(`FMPC_ADDR_SAMPLE_MATH, 16'h0FE6, 1'b1);
        read_check(`FMPC_ADDR_LED_TIMING_B, 16'hDFFC, 1'b1);
        reg_io(1'b1, 1'b0, `FMPC_ADDR_LED_TIMING_B, 16'hFFFF);
        read_check(`FMPC_ADDR_LED_TIMING_B, 16'hDFFF, 1'b1);
        reg_io(1'b1, 1'b0, `FMPC_ADDR_ENABLE_B, 16'hFFFF);
        read_check(`FMPC_ADDR_ENABLE_B, 16'h7F00, 1'b1);
        reg_io(1'b1, 1'b0, `FMPC_ADDR_SAMPLE_MATH, 16'h0000);
        check("intbuf", 16'(integrator_buffer_enable_r), 16'h0000);
    endtask

    // every enable code, reserved ones stay off
    task automatic test_enable();
        for (int c = 0; c < 4; c++)
        begin
            reg_io(1'b1, 1'b0, `FMPC_ADDR_ENABLE_B, {1'b0, 2'(c), 5'(c + 4), 8'h00});
            check("float on", 16'(float_on_r), 16'(c == 3));
            check("precon", 16'(precon_time_r), 16'(c + 4));
        end
    endtask

    // every sign code for both pairs and slots over sixteen pulses
    task automatic test_signs();
        logic [1:0] b12;
        logic [1:0] b34;
        logic [1:0] a12;
        logic [1:0] a34;
        logic [1:0] one;
        logic [1:0] two;
        logic [1:0] pos;
        for (int c = 0; c < 4; c++)
        begin
            b12 = 2'(c);
            b34 = 2'(3 - c);
            a12 = 2'(c) ^ 2'h1;
            a34 = 2'(c) ^ 2'h2;
            reg_io(1'b1, 1'b0, `FMPC_ADDR_SAMPLE_MATH,
                   {4'h0, b34, a34, 1'b0, b12, 2'h0, a12, 1'b0});
            for (int n = 0; n < 32; n++)
            begin
                pos = 2'(n);
                one = (n >= 16) ? b12 : a12;
                two = (n >= 16) ? b34 : a34;
                @(negedge sys_clk);
                sreq.valid     = 1'b1;
                sreq.slot_b    = (n >= 16);
                sreq.pulse_num = 8'(n % 16);
                @(negedge sys_clk);
                sreq.valid = 1'b0;
                check("sign valid", 16'(sign_valid_r), 16'h0001);
                check("sign", 16'(sign_sub_r), 16'(pos[1] ? two[~pos[0]] : one[~pos[0]]));
            end
        end
    endtask

    // unmapped access, read with write, frozen clock enable
    task automatic test_bus_corners();
        reg_io(1'b1, 1'b0, 8'h40, 16'hFFFF);
        read_check(8'h40, 16'h0000, 1'b0);
        reg_io(1'b1, 1'b0, `FMPC_ADDR_ENABLE_B, 16'h0800);
        reg_io(1'b1, 1'b1, `FMPC_ADDR_ENABLE_B, 16'h6A00);
        check("rd old", rd_data_r, 16'h0800);
        check("float on", 16'(float_on_r), 16'h0001);
        check("precon", 16'(precon_time_r), 16'h000A);
        @(negedge sys_clk);
        clk_en = 1'b0;
        reg_io(1'b1, 1'b0, `FMPC_ADDR_ENABLE_B, 16'h0000);
        check("frozen", 16'(float_on_r), 16'h0001);
        clk_en = 1'b1;
    endtask

    // back-to-back samples four pulses apart share one sign
    task automatic test_sign_repeat();
        reg_io(1'b1, 1'b0, `FMPC_ADDR_SAMPLE_MATH, 16'h0840);
        for (int p = 0; p < 4; p++)
        begin
            @(negedge sys_clk);
            sreq.valid  = 1'b1;
            sreq.slot_b = 1'b1;
            for (int g = 0; g < 4; g++)
            begin
                sreq.pulse_num = 8'(p + 4 * g);
                @(negedge sys_clk);
                check("sign repeat", 16'(sign_sub_r), 16'(p % 2 == 0));
            end
            sreq.valid = 1'b0;
        end
    endtask

    // reset in mid-run restores defaults even with the enable low
    task automatic test_mid_reset();
        reg_io(1'b1, 1'b0, `FMPC_ADDR_ENABLE_B, 16'h6A00);
        @(negedge sys_clk);
        rst    = 1'b1;
        clk_en = 1'b0;
        @(negedge sys_clk);
        rst    = 1'b0;
        clk_en = 1'b1;
        check("float on", 16'(float_on_r), 16'h0000);
        check("precon", 16'(precon_time_r), 16'h0008);
        check("width", 16'(pulse_width_r), 16'h0003);
    endtask

    // ---------------------------------------------------------------------
    // timeout and main sequence
    // ---------------------------------------------------------------------
    // cut a hang short
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_mismatch++;
            complete_run();
        end
    end

    initial
    begin
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        rst = 1'b0;
        test_reset();
        test_led_select();
        test_reserved();
        test_enable();
        test_signs();
        test_sign_repeat();
        test_bus_corners();
        test_mid_reset();
        complete_run();
    end
endmodule // fmpc_top_test
`default_nettype wire
